// ---- rx_message_mailbox_mapper.sv ----
// inbound message mailbox mapper, admission checks and direct-io command registers
//
// Contract
// - reset zeroes command registers, then idle until written
// - powered-down command unit: registers inaccessible, clock gated
// - each message consumes one sixteen-byte descriptor
// - oversized message answered error on every segment
// - error when queue head unset or torn down
// - error when queue has no free descriptor
// - retry new multi-segment message while queue busy multi-segment
// - in-order reception per flow is selectable
// - all mailboxes accepted, packets handled one at a time
// - single-packet segment field extends the mailbox
// - queue chosen from source, length, mailbox, letter fields
// - thirty-two mapping entries, low and high word
// - unmatched or non-existent queue answered error
// - zero mask bit excludes that field bit
// - source mismatch: error, capture, error pulse
// - promiscuous entry ignores source, masks still apply
// - single-segment six mailbox bits, multi-segment two
// - own queue per multi message, 64 descriptors
// - answer names segment so sender can resend
// - sixteen receive queues, single or multi
// - duplicate segment of busy message answered error
`timescale 1ns/1ps
module rx_message_mailbox_mapper #(
  parameter int NUM_ENTRIES = mbox_map_pkg::MAP_ENTRIES,
  parameter int NUM_QUEUES  = mbox_map_pkg::RX_QUEUES,
  parameter int FIFO_DEPTH  = mbox_map_pkg::FIFO_WORDS
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        cfg_wr_in,
  input  wire logic        cfg_rd_in,
  input  wire logic [11:0] cfg_addr_in,
  input  wire logic [31:0] cfg_wdata_in,
  output logic [31:0]      cfg_rdata_out,
  output logic             cfg_rvalid_out,
  input  wire logic        lsu_pd_in,
  output logic             lsu_clk_en_out,
  output logic             lsu_cmd_go_out,
  input  wire logic        msg_valid_in,
  output logic             msg_ready_out,
  input  wire logic [15:0] msg_src_in,
  input  wire logic [3:0]  msg_len_in,
  input  wire logic [3:0]  msg_seg_in,
  input  wire logic [1:0]  msg_mbox_in,
  input  wire logic [1:0]  msg_letter_in,
  input  wire logic [8:0]  msg_seg_bytes_in,
  output logic             resp_valid_out,
  input  wire logic        resp_ready_in,
  output logic [1:0]       resp_status_out,
  output logic [15:0]      resp_src_out,
  output logic [1:0]       resp_mbox_out,
  output logic [1:0]       resp_letter_out,
  output logic [3:0]       resp_seg_out,
  output logic             bd_valid_out,
  output logic [3:0]       bd_queue_out,
  output logic [31:0]      bd_addr_out,
  output logic             sec_err_out
);
  localparam int QN = mbox_map_pkg::RX_QUEUES;
  localparam int CW = mbox_map_pkg::LSU_WORDS;
  // ==========================================================================
  // inbound fifo, one packet taken at a time
  logic [mbox_map_pkg::PKT_W-1:0] pkt;
  logic        pkt_valid, take;
  logic [15:0] p_src;
  logic [3:0]  p_len, p_seg;
  logic [1:0]  p_mbox, p_let;
  logic [8:0]  p_bytes;
  logic        p_multi;
  logic [5:0]  p_mbox6;
  logic [19:0] p_key;

  msg_fifo #(.WIDTH(mbox_map_pkg::PKT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_in   (sys_clk_in),
    .rst_n_in     (rst_n_in),
    .in_valid_in  (msg_valid_in),
    .in_data_in   ({msg_src_in, msg_len_in, msg_seg_in, msg_mbox_in, msg_letter_in,
                    msg_seg_bytes_in}),
    .in_ready_out (msg_ready_out),
    .out_valid_out(pkt_valid),
    .out_data_out (pkt),
    .out_ready_in (take)
  );

  assign {p_src, p_len, p_seg, p_mbox, p_let, p_bytes} = pkt;
  assign p_multi = p_len != 4'h0;
  assign p_mbox6 = {p_seg, p_mbox};
  assign p_key   = {p_src, p_mbox, p_let};
  // ==========================================================================
  // registers
  logic [31:0] map_lo_reg [NUM_ENTRIES], map_lo_next [NUM_ENTRIES];
  logic [31:0] map_hi_reg [NUM_ENTRIES], map_hi_next [NUM_ENTRIES];
  logic [31:0] cmd_reg [CW], cmd_next [CW];
  logic [31:0] ctrl_reg, ctrl_next, bufsz_reg, bufsz_next, errcap_reg, errcap_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        rvalid_reg, rvalid_next, clk_en_reg, clk_en_next, go_reg, go_next;
  logic        map_sel, hdp_sel, free_sel, cmd_sel;
  logic [4:0]  m_idx;
  logic [3:0]  cq;
  logic [1:0]  c_idx;
  logic [31:0] head_reg [QN], head_next [QN];
  logic [6:0]  free_reg [QN], free_next [QN];
  logic [15:0] segmap_reg [QN], segmap_next [QN];
  logic [19:0] key_reg [QN], key_next [QN];
  logic [15:0] busy_reg, busy_next, tear;

  assign map_sel  = cfg_addr_in[11:8] == mbox_map_pkg::MAP_BASE[11:8];
  assign hdp_sel  = cfg_addr_in[11:6] == mbox_map_pkg::HDP_BASE[11:6];
  assign free_sel = cfg_addr_in[11:6] == mbox_map_pkg::FREE_BASE[11:6];
  assign cmd_sel  = cfg_addr_in[11:4] == mbox_map_pkg::CMD_BASE[11:4];
  assign m_idx    = cfg_addr_in[7:3];
  assign cq       = cfg_addr_in[5:2];
  assign c_idx    = cfg_addr_in[3:2];
  assign tear     = ctrl_reg[mbox_map_pkg::TEAR_LSB+:16];

  // software side: table, control, command unit and read-back
  always_comb begin
    map_lo_next = map_lo_reg;
    map_hi_next = map_hi_reg;
    cmd_next    = cmd_reg;
    ctrl_next   = ctrl_reg;
    bufsz_next  = bufsz_reg;
    go_next     = 1'b0;
    clk_en_next = !lsu_pd_in;
    rvalid_next = cfg_rd_in;
    rdata_next  = 32'h0000_0000;
    if (cfg_wr_in) begin
      if (map_sel && 32'(m_idx) < NUM_ENTRIES) begin
        if (cfg_addr_in[2]) begin
          map_hi_next[m_idx] = cfg_wdata_in & mbox_map_pkg::MAP_HI_WM;
        end else begin
          map_lo_next[m_idx] = cfg_wdata_in;
        end
      end else if (cfg_addr_in == mbox_map_pkg::CTRL_ADDR) begin
        ctrl_next = cfg_wdata_in;
      end else if (cfg_addr_in == mbox_map_pkg::BUFSZ_ADDR) begin
        bufsz_next = cfg_wdata_in;
      end else if (cmd_sel && !lsu_pd_in) begin
        cmd_next[c_idx] = cfg_wdata_in;
        go_next = c_idx == 2'(CW - 1);
      end
    end
    if (cfg_rd_in) begin
      if (map_sel && 32'(m_idx) < NUM_ENTRIES) begin
        rdata_next = cfg_addr_in[2] ? map_hi_reg[m_idx] : map_lo_reg[m_idx];
      end else if (hdp_sel) begin
        rdata_next = head_reg[cq];
      end else if (free_sel) begin
        rdata_next = {25'h0, free_reg[cq]};
      end else if (cfg_addr_in == mbox_map_pkg::CTRL_ADDR) begin
        rdata_next = ctrl_reg;
      end else if (cfg_addr_in == mbox_map_pkg::BUFSZ_ADDR) begin
        rdata_next = bufsz_reg;
      end else if (cfg_addr_in == mbox_map_pkg::ERRCAP_ADDR) begin
        rdata_next = errcap_reg;
      end else if (cfg_addr_in == mbox_map_pkg::BUSY_ADDR) begin
        rdata_next = {16'h0, busy_reg};
      end else if (cmd_sel && !lsu_pd_in) begin
        rdata_next = cmd_reg[c_idx];
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NUM_ENTRIES; i++) begin
        map_lo_reg[i] <= mbox_map_pkg::MAP_LO_RST;
        map_hi_reg[i] <= mbox_map_pkg::MAP_HI_RST;
      end
      for (int i = 0; i < CW; i++) begin
        cmd_reg[i] <= 32'h0000_0000;
      end
      ctrl_reg   <= 32'h0000_0000;
      bufsz_reg  <= mbox_map_pkg::BUFSZ_RST;
      rdata_reg  <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
      clk_en_reg <= 1'b0;
      go_reg     <= 1'b0;
    end else begin
      map_lo_reg <= map_lo_next;
      map_hi_reg <= map_hi_next;
      cmd_reg    <= cmd_next;
      ctrl_reg   <= ctrl_next;
      bufsz_reg  <= bufsz_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      clk_en_reg <= clk_en_next;
      go_reg     <= go_next;
    end
  end
  // ==========================================================================
  // entry match, every entry compared in parallel
  logic [NUM_ENTRIES-1:0] ent_hit, ent_pass;
  logic [3:0] win_qid;

  for (genvar e = 0; e < NUM_ENTRIES; e++) begin : g_ent
    logic [31:0] lo, hi;
    logic [5:0]  mmask;
    assign lo = map_lo_reg[e];
    assign hi = map_hi_reg[e];
    // multi-segment packets reuse the extension bits as segment number
    assign mmask = hi[mbox_map_pkg::SEGMAP_BIT] ? {4'h0, lo[mbox_map_pkg::MMASK_LSB+:2]}
                                                : lo[mbox_map_pkg::MMASK_LSB+:6];
    assign ent_hit[e] = (hi[mbox_map_pkg::SEGMAP_BIT] == p_multi)
      && (((lo[mbox_map_pkg::MBOX_LSB+:6] ^ p_mbox6) & mmask) == 6'h00)
      && (((lo[mbox_map_pkg::LET_LSB+:2] ^ p_let) & lo[mbox_map_pkg::LMASK_LSB+:2])
          == 2'h0);
    assign ent_pass[e] = ent_hit[e]
      && (hi[mbox_map_pkg::PROM_BIT] || lo[15:0] == p_src);
  end

  always_comb begin
    win_qid = 4'h0;
    for (int i = NUM_ENTRIES - 1; i >= 0; i--) begin
      if (ent_pass[i]) begin
        win_qid = map_hi_reg[i][mbox_map_pkg::QID_LSB+:4];
      end
    end
  end
  // ==========================================================================
  // admission decision
  mbox_map_pkg::resp_e dec;
  logic        q_ok, q_busy, too_big, complete, sec_err;
  logic        hold_v_reg, hold_v_next;
  logic [19:0] hold_key_reg, hold_key_next;
  logic [31:0] q_head;
  logic [6:0]  q_free;
  logic [15:0] cur_map, new_map, full_map;
  logic [13:0] msg_bytes;

  assign q_head    = head_reg[win_qid];
  assign q_free    = free_reg[win_qid];
  assign q_busy    = busy_reg[win_qid];
  assign msg_bytes = 14'(p_len + 5'h01) * 14'(p_bytes);
  // compare against the whole size word so a large buffer setting never wraps to a small one
  assign too_big   = {18'h0_0000, msg_bytes} > bufsz_reg;
  assign cur_map   = q_busy ? segmap_reg[win_qid] : 16'h0000;
  assign new_map   = cur_map | (16'h0001 << p_seg);
  assign full_map  = 16'hffff >> (4'hf - p_len);
  assign complete  = !p_multi || new_map == full_map;
  assign q_ok      = |ent_pass && 32'(win_qid) < NUM_QUEUES && q_head != 32'h0
                     && !tear[win_qid] && q_free != 7'h00 && !too_big;

  always_comb begin
    dec = mbox_map_pkg::RESP_ERROR;
    sec_err = |ent_hit && !(|ent_pass);
    if (q_ok) begin
      dec = mbox_map_pkg::RESP_DONE;
      if (p_multi && q_busy) begin
        if (key_reg[win_qid] != p_key) begin
          dec = mbox_map_pkg::RESP_RETRY;
        end else if (cur_map[p_seg]) begin
          dec = mbox_map_pkg::RESP_ERROR;
        end
      end else if (ctrl_reg[mbox_map_pkg::INORDER_BIT] && hold_v_reg
                   && hold_key_reg[19:4] == p_src && hold_key_reg != p_key) begin
        dec = mbox_map_pkg::RESP_RETRY;
      end
    end
  end
  // ==========================================================================
  // queue state and responses
  logic        rv_reg, rv_next, bdv_reg, bdv_next, sec_reg, sec_next;
  logic [1:0]  st_reg, st_next;
  logic [29:0] rinfo_reg, rinfo_next;
  logic [3:0]  bdq_reg, bdq_next;
  logic [31:0] bda_reg, bda_next;

  // one packet per cycle at most, and only while the answer slot is empty or its answer is being taken
  assign take = pkt_valid && (!rv_reg || resp_ready_in);

  always_comb begin
    head_next = head_reg;
    free_next = free_reg;
    segmap_next = segmap_reg;
    key_next = key_reg;
    busy_next = busy_reg & ~tear;
    hold_v_next = hold_v_reg;
    hold_key_next = hold_key_reg;
    rv_next = rv_reg && !resp_ready_in;
    st_next = st_reg;
    rinfo_next = rinfo_reg;
    bdv_next = 1'b0;
    bdq_next = bdq_reg;
    bda_next = bda_reg;
    sec_next = 1'b0;
    errcap_next = errcap_reg;
    if (cfg_wr_in && hdp_sel && head_reg[cq] == 32'h0) begin
      head_next[cq] = {cfg_wdata_in[31:2], 2'b00};
    end
    if (cfg_wr_in && free_sel) begin
      free_next[cq] = cfg_wdata_in[6:0];
    end
    if (take) begin
      rv_next = 1'b1;
      st_next = dec;
      rinfo_next = {p_src, p_mbox, p_let, p_seg, 6'(p_len)};
      if (sec_err) begin
        sec_next = 1'b1;
        errcap_next = {8'h00, p_let, p_mbox6, p_src};
      end
      if (dec == mbox_map_pkg::RESP_DONE) begin
        if (hold_v_reg && hold_key_reg == p_key) begin
          hold_v_next = 1'b0;
        end
        if (complete) begin
          bdv_next = 1'b1;
          bdq_next = win_qid;
          bda_next = q_head;
          head_next[win_qid] = q_free == 7'h01 ? 32'h0 : q_head + mbox_map_pkg::BD_BYTES;
          free_next[win_qid] = q_free - 7'h01;
          busy_next[win_qid] = 1'b0;
        end else begin
          busy_next[win_qid] = 1'b1;
          key_next[win_qid] = p_key;
          segmap_next[win_qid] = new_map;
        end
      end else if (dec == mbox_map_pkg::RESP_RETRY && ctrl_reg[mbox_map_pkg::INORDER_BIT]
                   && !hold_v_reg) begin
        hold_v_next = 1'b1;
        hold_key_next = p_key;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < QN; i++) begin
        head_reg[i] <= 32'h0000_0000;
        free_reg[i] <= 7'h00;
        segmap_reg[i] <= 16'h0000;
        key_reg[i] <= 20'h0_0000;
      end
      busy_reg <= 16'h0000;
      hold_v_reg <= 1'b0;
      hold_key_reg <= 20'h0_0000;
      rv_reg <= 1'b0;
      st_reg <= 2'h0;
      rinfo_reg <= 30'h0000_0000;
      bdv_reg <= 1'b0;
      bdq_reg <= 4'h0;
      bda_reg <= 32'h0000_0000;
      sec_reg <= 1'b0;
      errcap_reg <= 32'h0000_0000;
    end else begin
      head_reg <= head_next;
      free_reg <= free_next;
      segmap_reg <= segmap_next;
      key_reg <= key_next;
      busy_reg <= busy_next;
      hold_v_reg <= hold_v_next;
      hold_key_reg <= hold_key_next;
      rv_reg <= rv_next;
      st_reg <= st_next;
      rinfo_reg <= rinfo_next;
      bdv_reg <= bdv_next;
      bdq_reg <= bdq_next;
      bda_reg <= bda_next;
      sec_reg <= sec_next;
      errcap_reg <= errcap_next;
    end
  end

  assign cfg_rdata_out   = rdata_reg;
  assign cfg_rvalid_out  = rvalid_reg;
  assign lsu_clk_en_out  = clk_en_reg;
  assign lsu_cmd_go_out  = go_reg;
  assign resp_valid_out  = rv_reg;
  assign resp_status_out = st_reg;
  assign resp_src_out    = rinfo_reg[29:14];
  assign resp_mbox_out   = rinfo_reg[13:12];
  assign resp_letter_out = rinfo_reg[11:10];
  assign resp_seg_out    = rinfo_reg[9:6];
  assign bd_valid_out    = bdv_reg;
  assign bd_queue_out    = bdq_reg;
  assign bd_addr_out     = bda_reg;
  assign sec_err_out     = sec_reg;
  // ==========================================================================
  // checks
  logic cmd_any;
  assign cmd_any = (cmd_reg[0] | cmd_reg[1] | cmd_reg[2] | cmd_reg[3]) != 32'h0;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_err_out;
    resp_valid_out && resp_status_out == mbox_map_pkg::RESP_ERROR;
  endsequence
  sequence s_unmapped;
    take && !(|ent_hit);
  endsequence

  chk_unmapped_error: assert property (s_unmapped |=> s_err_out)
    else $error("unmapped message not answered with error");
  // a second mismatching packet right behind the first may keep the pulse high
  chk_source_error: assert property (take && |ent_hit && !(|ent_pass)
    |=> s_err_out and (sec_err_out ##1 (!sec_err_out || $past(take))))
    else $error("source mismatch not flagged");
  chk_no_head_error: assert property (take && |ent_pass && q_head == 32'h0
    |=> s_err_out)
    else $error("uninitialised queue accepted a message");
  chk_overflow_error: assert property (take && |ent_pass && q_free == 7'h00
    |=> s_err_out)
    else $error("full queue accepted a message");
  chk_busy_retry: assert property (take && q_ok && p_multi && q_busy
    && key_reg[win_qid] != p_key |=> resp_status_out == mbox_map_pkg::RESP_RETRY)
    else $error("busy queue did not retry");
  chk_dup_segment: assert property (take && q_ok && p_multi && q_busy
    && key_reg[win_qid] == p_key && cur_map[p_seg] |=> s_err_out)
    else $error("duplicate segment not answered with error");
  chk_bd_advance: assert property (take && dec == mbox_map_pkg::RESP_DONE && complete
    |=> bd_valid_out && bd_addr_out == $past(q_head)
        && (head_reg[bd_queue_out] == bd_addr_out + mbox_map_pkg::BD_BYTES
            || head_reg[bd_queue_out] == 32'h0))
    else $error("descriptor step is not sixteen bytes");
  chk_resp_stall: assert property (resp_valid_out && !resp_ready_in
    |=> resp_valid_out && $stable(resp_status_out) && $stable(resp_src_out))
    else $error("pending answer changed before taken");
  chk_lsu_reset: assert property (disable iff (1'b0) !rst_n_in |=> !cmd_any)
    else $error("command registers not cleared by reset");
  chk_lsu_pd_read: assert property (cfg_rd_in && cmd_sel && lsu_pd_in
    |=> cfg_rvalid_out && cfg_rdata_out == 32'h0 && !lsu_clk_en_out)
    else $error("powered-down command unit visible");
endmodule // rx_message_mailbox_mapper

// ---- mbox_map_pkg.sv ----
// constants, register map and response codes of the inbound mailbox mapper
package mbox_map_pkg;
  // ==========================================================================
  // sizes
  localparam int MAP_ENTRIES = 32;
  localparam int RX_QUEUES   = 16;
  localparam int FIFO_WORDS  = 16;
  localparam int LSU_WORDS   = 4;
  localparam int BD_WORDS    = 4;
  localparam logic [31:0] BD_BYTES = 32'(BD_WORDS * 4);
  localparam int PKT_W       = 37;
  // ==========================================================================
  // register offsets
  localparam logic [11:0] CMD_BASE    = 12'h400;
  localparam logic [11:0] HDP_BASE    = 12'h600;
  localparam logic [11:0] FREE_BASE   = 12'h680;
  localparam logic [11:0] CTRL_ADDR   = 12'h6c0;
  localparam logic [11:0] BUFSZ_ADDR  = 12'h6c4;
  localparam logic [11:0] ERRCAP_ADDR = 12'h6c8;
  localparam logic [11:0] BUSY_ADDR   = 12'h6cc;
  localparam logic [11:0] MAP_BASE    = 12'h800;
  // ==========================================================================
  // field positions
  localparam int LMASK_LSB   = 30;
  localparam int MMASK_LSB   = 24;
  localparam int LET_LSB     = 22;
  localparam int MBOX_LSB    = 16;
  localparam int QID_LSB     = 2;
  localparam int PROM_BIT    = 1;
  localparam int SEGMAP_BIT  = 0;
  localparam int INORDER_BIT = 0;
  localparam int TEAR_LSB    = 16;
  // ==========================================================================
  // reset values and write masks
  localparam logic [31:0] MAP_LO_RST = 32'hff00_0000;
  localparam logic [31:0] MAP_HI_RST = 32'h0000_0100;
  localparam logic [31:0] MAP_HI_WM  = 32'h0000_033f;
  localparam logic [31:0] BUFSZ_RST  = 32'h0000_1000;
  // ==========================================================================
  // response status
  typedef enum logic [1:0] {
    RESP_DONE  = 2'h0,
    RESP_RETRY = 2'h1,
    RESP_ERROR = 2'h3
  } resp_e;
endpackage

// ---- msg_fifo.sv ----
// inbound packet fifo with registered read data
`timescale 1ns/1ps
module msg_fifo #(
  parameter int WIDTH = mbox_map_pkg::PKT_W,
  parameter int DEPTH = mbox_map_pkg::FIFO_WORDS
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  // ==========================================================================
  // storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [AW:0]      count_reg, count_next;
  logic             out_valid_reg, out_valid_next, in_ready_reg, in_ready_next;
  logic [WIDTH-1:0] out_data_reg, out_data_next;
  logic             push, load;

  // the output stage holds one more word; ready is registered from the next count, so it drops as the count reaches DEPTH
  always_comb begin
    push = in_valid_in && in_ready_reg;
    load = (count_reg != '0) && (!out_valid_reg || out_ready_in);
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = load ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    in_ready_next = count_next < (AW+1)'(DEPTH);
    out_valid_next = load || (out_valid_reg && !out_ready_in);
    out_data_next = load ? mem[rd_ptr_reg] : out_data_reg;
  end

  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg    <= '0;
      rd_ptr_reg    <= '0;
      count_reg     <= '0;
      out_valid_reg <= 1'b0;
      in_ready_reg  <= 1'b0;
      out_data_reg  <= '0;
    end else begin
      wr_ptr_reg    <= wr_ptr_next;
      rd_ptr_reg    <= rd_ptr_next;
      count_reg     <= count_next;
      out_valid_reg <= out_valid_next;
      in_ready_reg  <= in_ready_next;
      out_data_reg  <= out_data_next;
    end
  end

  assign in_ready_out  = in_ready_reg;
  assign out_valid_out = out_valid_reg;
  assign out_data_out  = out_data_reg;
endmodule // msg_fifo

// ---- msg_sender.sv ----
// remote endpoint model offering inbound message packets
`timescale 1ns/1ps
module msg_sender (
  input  wire logic        sys_clk_in,
  input  wire logic        ready_in,
  output logic             valid_out,
  output logic [36:0]      pkt_out
);
  initial begin
    valid_out = 1'b0;
    pkt_out = 37'h0;
  end
  // =====================================================
  // one packet per call, held until taken
  task automatic send(input logic [36:0] pkt);
    @(posedge sys_clk_in);
    valid_out <= 1'b1;
    pkt_out <= pkt;
    forever begin
      @(posedge sys_clk_in);
      if (ready_in) break;
    end
    valid_out <= 1'b0;
    // released fields are scrambled so a stale capture cannot pass
    pkt_out <= ~pkt;
  endtask
endmodule // msg_sender

// ---- tb_rx_message_mailbox_mapper.sv ----
// self-checking bench of the inbound mailbox mapper
`timescale 1ns/1ps
module tb_rx_message_mailbox_mapper;
  logic        sys_clk_in = 1'b0, rst_n_in = 1'b0, cfg_wr_in = 1'b0, cfg_rd_in = 1'b0;
  logic        resp_ready_in = 1'b1;
  logic        lsu_pd_in = 1'b0, cfg_rvalid_out, lsu_clk_en_out, lsu_cmd_go_out;
  logic        msg_valid_in, msg_ready_out, resp_valid_out, bd_valid_out, sec_err_out;
  logic [11:0] cfg_addr_in = 12'h000;
  logic [31:0] cfg_wdata_in = 32'h0, cfg_rdata_out, bd_addr_out, rng = 32'h0000_f41b;
  logic [36:0] pkt;
  logic [15:0] resp_src_out;
  logic [3:0]  resp_seg_out, bd_queue_out;
  logic [1:0]  resp_status_out, resp_mbox_out, resp_letter_out;
  int          bad_count = 0, checked = 0, cycles = 0;
  localparam logic [36:0] TWO_SEG = {20'h0_0001, 17'h0_0000};
  always #2 sys_clk_in = ~sys_clk_in;
  rx_message_mailbox_mapper u_rx_message_mailbox_mapper (.sys_clk_in, .rst_n_in, .cfg_wr_in,
    .cfg_rd_in, .cfg_addr_in, .cfg_wdata_in, .cfg_rdata_out, .cfg_rvalid_out, .lsu_pd_in,
    .lsu_clk_en_out, .lsu_cmd_go_out, .msg_valid_in, .msg_ready_out, .msg_src_in(pkt[36:21]),
    .msg_len_in(pkt[20:17]), .msg_seg_in(pkt[16:13]), .msg_mbox_in(pkt[12:11]),
    .msg_letter_in(pkt[10:9]), .msg_seg_bytes_in(pkt[8:0]), .resp_valid_out,
    .resp_ready_in, .resp_status_out, .resp_src_out, .resp_mbox_out, .resp_letter_out,
    .resp_seg_out, .bd_valid_out, .bd_queue_out, .bd_addr_out, .sec_err_out);
  msg_sender u_msg_sender (.sys_clk_in, .ready_in(msg_ready_out), .valid_out(msg_valid_in),
    .pkt_out(pkt));
  // =====================================================
  // helpers
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [36:0] mk(logic [15:0] s, logic [3:0] g, logic [1:0] m, l);
    return {s, 4'h0, g, m, l, 9'd256};
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    cfg_wr_in <= 1'b1;
    cfg_addr_in <= a;
    cfg_wdata_in <= d;
    @(posedge sys_clk_in);
    cfg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge sys_clk_in);
    cfg_rd_in <= 1'b1;
    cfg_addr_in <= a;
    @(posedge sys_clk_in);
    cfg_rd_in <= 1'b0;
    #1 chk("rdata", cfg_rvalid_out ? cfg_rdata_out : 32'hdead_beef, exp);
  endtask
  task automatic msg(input logic [36:0] p, input logic [1:0] st, input logic [31:0] ad,
                     input logic sec);
    int n;
    chk("msg_ready", {31'h0, msg_ready_out}, 32'h1);
    u_msg_sender.send(p);
    // a random stall of the answer slot makes the pending answer hold
    void'(xs());
    resp_ready_in <= rng[0];
    n = 0;
    do begin
      @(posedge sys_clk_in);
      #1 n++;
    end while (resp_valid_out !== 1'b1 && n < 60);
    chk("resp_valid", {31'h0, resp_valid_out}, 32'h1);
    chk("status", {30'h0, resp_status_out}, {30'h0, st});
    chk("bd_valid", {31'h0, bd_valid_out}, {31'h0, st == 2'h0 && ad != 32'h0});
    if (st == 2'h0 && ad != 32'h0) begin
      chk("bd_addr", bd_addr_out, ad);
      // each queue head sits at its queue number times 0x1000
      chk("bd_queue", {28'h0, bd_queue_out}, {28'h0, ad[15:12]});
    end
    chk("sec_err", {31'h0, sec_err_out}, {31'h0, sec});
    chk("resp_echo", {8'h00, resp_src_out, resp_mbox_out, resp_letter_out, resp_seg_out},
        {8'h00, p[36:21], p[12:11], p[10:9], p[16:13]});
    @(posedge sys_clk_in);
    resp_ready_in <= 1'b1;
  endtask
  task automatic complete_run();
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  // =====================================================
  // scenarios
  initial begin
    repeat (10) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    rd(mbox_map_pkg::MAP_BASE, mbox_map_pkg::MAP_LO_RST);
    rd(mbox_map_pkg::MAP_BASE + 12'h4, mbox_map_pkg::MAP_HI_RST);
    rd(mbox_map_pkg::CMD_BASE, 32'h0);
    rd(12'hffc, 32'h0);
    wr(mbox_map_pkg::CMD_BASE + 12'hc, 32'h1);
    #1 chk("cmd_go", {31'h0, lsu_cmd_go_out}, 32'h1);
    chk("clk_en", {31'h0, lsu_clk_en_out}, 32'h1);
    @(posedge sys_clk_in) lsu_pd_in <= 1'b1;
    rd(mbox_map_pkg::CMD_BASE + 12'hc, 32'h0);
    chk("clk_en", {31'h0, lsu_clk_en_out}, 32'h0);
    @(posedge sys_clk_in) lsu_pd_in <= 1'b0;
    msg(mk(16'h1234, 4'h0, 2'h1, 2'h2), 2'h3, 32'h0, 1'b0);
    // table is programmed only after reset
    wr(mbox_map_pkg::MAP_BASE, {2'h3, 6'h3f, 2'h2, 6'h01, 16'h1234});
    wr(mbox_map_pkg::MAP_BASE + 12'h4, 32'h0000_010c);
    wr(mbox_map_pkg::MAP_BASE + 12'h8, 32'hc000_0000);
    wr(mbox_map_pkg::MAP_BASE + 12'hc, 32'h0000_0116);
    wr(mbox_map_pkg::HDP_BASE + 12'hc, 32'h3000);
    wr(mbox_map_pkg::FREE_BASE + 12'hc, 32'h2);
    wr(mbox_map_pkg::HDP_BASE + 12'h14, 32'h5000);
    wr(mbox_map_pkg::FREE_BASE + 12'h14, 32'h8);
    rd(mbox_map_pkg::MAP_BASE + 12'h4, 32'h0000_010c);
    msg(mk(16'h1234, 4'h1, 2'h1, 2'h2), 2'h3, 32'h0, 1'b0);
    msg(mk(16'h1234, 4'h0, 2'h1, 2'h2), 2'h0, 32'h3000, 1'b0);
    msg(mk(16'h1234, 4'h0, 2'h1, 2'h2), 2'h0, 32'h3010, 1'b0);
    msg(mk(16'h1234, 4'h0, 2'h1, 2'h2), 2'h3, 32'h0, 1'b0);
    msg(mk(16'(xs()) | 16'h0001, 4'h0, 2'h1, 2'h2), 2'h3, 32'h0, 1'b1);
    for (int k = 0; k < 4; k++) begin
      void'(xs());
      msg(mk(rng[15:0], rng[19:16], rng[21:20], 2'h0), 2'h0, 32'h5000 + 32'(k) * 32'h10,
          1'b0);
    end
    // a two-segment message on an entry of its own with a full letter mask
    wr(mbox_map_pkg::MAP_BASE + 12'h10, {2'h3, 6'h00, 2'h1, 6'h02, 16'h0042});
    wr(mbox_map_pkg::MAP_BASE + 12'h14, 32'h0000_0119);
    wr(mbox_map_pkg::HDP_BASE + 12'h18, 32'h6000);
    wr(mbox_map_pkg::FREE_BASE + 12'h18, 32'h4);
    msg(mk(16'h0042, 4'h0, 2'h2, 2'h1) | TWO_SEG, 2'h0, 32'h0, 1'b0);
    msg(mk(16'h0042, 4'h0, 2'h3, 2'h1) | TWO_SEG, 2'h1, 32'h0, 1'b0);
    msg(mk(16'h0042, 4'h0, 2'h2, 2'h1) | TWO_SEG, 2'h3, 32'h0, 1'b0);
    msg(mk(16'h0042, 4'h1, 2'h2, 2'h1) | TWO_SEG, 2'h0, 32'h6000, 1'b0);
    wr(mbox_map_pkg::BUFSZ_ADDR, 32'h80);
    msg(mk(16'h0077, 4'h2, 2'h3, 2'h0), 2'h3, 32'h0, 1'b0);
    complete_run();
  end
endmodule // tb_rx_message_mailbox_mapper
